// ---- inc/parsq_pkg.sv ----
package parsq_pkg;
    localparam int CLK_NS = 8;

    function automatic int ns2cyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    localparam int T_LD_NS     = 100;
    localparam int T_YSYNC_NS  = 50;
    localparam int T_YCLK_NS   = 100;
    localparam int T_BSET_NS   = 25;
    localparam int T_PRE_NS    = 400;
    localparam int T_SDS_NS    = 2000;
    localparam int T_SNDR_NS   = 2400;
    localparam int T_RST_NS    = 400;
    localparam int T_BHOLD_NS  = 100;
    localparam int T_CALDLY_NS = 25;
    localparam int T_CAL_NS    = 200;
    localparam int T_CALOFF_NS = 50;
    localparam int T_XHALF_NS  = 50;

    localparam int C_LD     = ns2cyc(T_LD_NS);
    localparam int C_YSYNC  = ns2cyc(T_YSYNC_NS);
    localparam int C_YCLK   = ns2cyc(T_YCLK_NS);
    localparam int C_BSET   = ns2cyc(T_BSET_NS);
    localparam int C_PRE    = ns2cyc(T_PRE_NS);
    localparam int C_SDS    = ns2cyc(T_SDS_NS);
    localparam int C_SNDR   = ns2cyc(T_SNDR_NS);
    localparam int C_RST    = ns2cyc(T_RST_NS);
    localparam int C_BHOLD  = ns2cyc(T_BHOLD_NS);
    localparam int C_CALDLY = ns2cyc(T_CALDLY_NS);
    localparam int C_CAL    = ns2cyc(T_CAL_NS);
    localparam int C_CALOFF = ns2cyc(T_CALOFF_NS);
    localparam int C_XHALF  = ns2cyc(T_XHALF_NS);

    localparam int PIX_LAT    = 6;
    localparam int CLEAR_ROWS = 1023;
    localparam int PIX_W      = 12;
    localparam int FIFO_DEPTH = 4;

    localparam logic [2:0] BS_SETUP = 3'h0;
    localparam logic [2:0] BS_PRE   = 3'h1;
    localparam logic [2:0] BS_SIG   = 3'h2;
    localparam logic [2:0] BS_RST   = 3'h3;
    localparam logic [2:0] BS_REF   = 3'h4;
    localparam logic [2:0] BS_HOLD  = 3'h5;
    localparam logic [2:0] BS_DONE  = 3'h6;

    typedef struct packed {
        logic [9:0] start_row;
        logic [9:0] start_col;
        logic [9:0] end_row;
        logic [9:0] end_col;
    } parsq_win_t;

    typedef struct packed {
        logic [9:0] addr;
        logic       ld_y;
        logic       ld_x;
        logic       clk_yrd;
        logic       sync_yrd;
        logic       clk_reset_line_pointer;
        logic       sync_reset_line_pointer;
        logic       pointer_select;
        logic       blank;
        logic       column_a;
        logic       samp_s;
        logic       samp_r;
        logic       row_reset;
        logic       cal;
        logic       clk_x;
        logic       sync_x;
    } parsq_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_LOAD  = 7'h02,
        ST_YSEL  = 7'h04,
        ST_BLANK = 7'h08,
        ST_CAL   = 7'h10,
        ST_PIX   = 7'h20,
        ST_WAIT  = 7'h40
    } parsq_state_t;

    typedef enum logic [5:0] {
        PH_EXPOSE  = 6'h01,
        PH_READ    = 6'h02,
        PH_CLEAR   = 6'h04,
        PH_BLACK   = 6'h08,
        PH_EXPWAIT = 6'h10,
        PH_SIGNAL  = 6'h20
    } parsq_phase_t;
endpackage

// ---- hw/parsq_ctrl.sv ----
// Function
// - load start row/col, then init both pointers
// - destructive exposure counted in whole lines
// - destructive expose: reset rows, one line each
// - destructive read: select, amplify, read, advance
// - reset pointer advances with every read line
// - second reset pulse may be omitted
// - without it, blanking held 100 ns after
// - calibration 25 ns after blanking, frame/line
// - calibrate gain amplifier at every frame start
// - nondestructive: clear rows 1..1023 first
// - then read window black levels
// - after wait, read window signal levels
// - nondestructive wait is any cycle count
// - one vertical pointer may serve all phases
// - pointer select 100 ns around substituted reset
// - nondestructive calibration 25 ns after blanking
// - pixel clock runs at twice pixel rate
// - pixel clock period >=100 ns, 50% duty
// - shifting starts 50 ns after calibration ends
// - resync pixel pointer after every blanking; clear-pass lines do not shift or resync
// - line: select, blanking, then pixel readout; clear-pass lines end after blanking
`timescale 1ns/1ps
module parsq_fifo #(
    parameter int W = 12,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]      mem [D];
    logic [AW-1:0]     wp, rp, next_wp, next_rp;
    logic [AW:0]       cnt, next_cnt;
    logic              wr, rd;

    assign in_ready  = cnt < (AW+1)'(D);
    assign out_valid = cnt != '0;
    assign out_data  = mem[rp];

    always_comb begin
        wr       = in_valid && in_ready;
        rd       = out_valid && out_ready;
        next_wp  = wr ? ((wp == AW'(D-1)) ? '0 : AW'(wp + 1'b1)) : wp;
        next_rp  = rd ? ((rp == AW'(D-1)) ? '0 : AW'(rp + 1'b1)) : rp;
        next_cnt = (AW+1)'(cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else if (clk_en) begin
            wp  <= next_wp;
            rp  <= next_rp;
            cnt <= next_cnt;
        end
    end

    // storage needs no reset; empty flag guards stale words
    always_ff @(posedge clk) begin
        if (clk_en && wr) begin
            mem[wp] <= in_data;
        end
    end
endmodule // parsq_fifo

module parsq_ctrl
    import parsq_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             start,
    input  wire logic             destructive_mode,
    input  wire parsq_win_t       win,
    input  wire logic [9:0]       exposure_lines,
    input  wire logic [31:0]      exposure_wait,
    input  wire logic             cal_each_line,
    input  wire logic [PIX_W-1:0] pix_pin,
    input  wire logic             out_ready,
    output logic                  out_valid,
    output logic [PIX_W-1:0]      out_data,
    output logic                  busy,
    output logic                  frame_done,
    output parsq_pins_t           pins
);
    parsq_state_t     st, next_st;
    parsq_phase_t     ph, next_ph;
    parsq_pins_t      next_pins;
    logic [2:0]       step, next_step, bn;
    logic [15:0]      tmr, next_tmr;
    logic [10:0]      row_cnt, next_row, rows, ncols;
    logic [11:0]      xe, next_xe, xtotal, xd;
    logic [31:0]      exp_cnt, next_exp;
    logic             first, next_first, cal_pend, next_cal, next_done;
    logic             push, lend, cap, cal_now, fifo_ready;
    logic [PIX_W-1:0] pix_s1, pix_s2;

    function automatic logic [15:0] ld(input int c);
        return 16'(c - 1);
    endfunction

    function automatic logic readline(input parsq_phase_t p);
        return p inside {PH_READ, PH_BLACK, PH_SIGNAL};
    endfunction

    function automatic logic step_on(input parsq_phase_t p, input logic [2:0] s);
        return (s == BS_SETUP) || (s == BS_HOLD)
            || (s == BS_PRE && readline(p))
            || (s == BS_SIG && p inside {PH_READ, PH_SIGNAL})
            || (s == BS_RST && p inside {PH_EXPOSE, PH_READ, PH_CLEAR})
            || (s == BS_REF && p inside {PH_READ, PH_BLACK});
    endfunction

    // the destructive read has no second reset after the reference sample
    function automatic logic [2:0] blank_next(input parsq_phase_t p, input logic [2:0] s);
        logic [2:0] n;
        n = 3'(s + 3'h1);
        for (int i = 0; i < 5; i++) begin
            if (n < BS_DONE && !step_on(p, n)) begin
                n = 3'(n + 3'h1);
            end
        end
        return n;
    endfunction

    function automatic logic [15:0] blank_len(input parsq_phase_t p, input logic [2:0] s);
        unique case (s)
            BS_SETUP:       return ld(C_BSET);
            BS_PRE:         return ld(C_PRE);
            BS_SIG, BS_REF: return (p == PH_READ) ? ld(C_SDS) : ld(C_SNDR);
            BS_RST:         return ld(C_RST);
            default:        return ld(C_BHOLD);
        endcase
    endfunction

    assign busy   = st != ST_IDLE;
    assign ncols  = 11'({1'b0, win.end_col} - {1'b0, win.start_col} + 11'h001);
    assign xtotal = 12'({ncols, 1'b0} + 12'(PIX_LAT));
    assign xd     = 12'(xe - 12'(PIX_LAT));
    // a pixel leaves every second shift, the first one after the pipeline delay
    assign cap     = xe >= 12'(PIX_LAT) && !xd[0];
    assign cal_now = cal_each_line || cal_pend;

    always_comb begin
        unique case (ph)
            PH_EXPOSE: rows = (exposure_lines == '0) ? 11'h001 : {1'b0, exposure_lines};
            PH_CLEAR:  rows = 11'(CLEAR_ROWS);
            default:   rows = 11'({1'b0, win.end_row} - {1'b0, win.start_row} + 11'h001);
        endcase
    end

    always_comb begin
        next_st    = st;
        next_ph    = ph;
        next_step  = step;
        next_tmr   = (tmr != '0) ? 16'(tmr - 16'h0001) : tmr;
        next_row   = row_cnt;
        next_xe    = xe;
        next_first = first;
        next_cal   = cal_pend;
        next_exp   = exp_cnt;
        next_done  = 1'b0;
        push       = 1'b0;
        lend       = 1'b0;
        bn         = blank_next(ph, step);
        next_pins  = '0;
        next_pins.addr  = pins.addr;
        next_pins.clk_x = pins.clk_x;
        unique case (st)
            ST_IDLE: begin
                if (start) begin
                    next_st    = ST_LOAD;
                    next_step  = 3'h0;
                    next_tmr   = ld(C_LD);
                    next_ph    = destructive_mode ? PH_EXPOSE : PH_CLEAR;
                    next_cal   = 1'b1;
                    next_first = 1'b1;
                    next_row   = '0;
                end
            end
            ST_LOAD: begin
                if (tmr == '0) begin
                    next_step = 3'(step + 3'h1);
                    next_tmr  = ld(C_LD);
                    if (step == 3'h5) begin
                        next_st   = ST_YSEL;
                        next_step = 3'h0;
                        next_tmr  = ld(C_YSYNC);
                    end
                end
            end
            ST_YSEL: begin
                if (tmr == '0) begin
                    next_step = 3'(step + 3'h1);
                    next_tmr  = ld(C_YCLK);
                    if (step == 3'h2) begin
                        next_st   = ST_BLANK;
                        next_step = BS_SETUP;
                        next_tmr  = ld(C_BSET);
                    end
                end
            end
            ST_BLANK: begin
                if (tmr == '0) begin
                    if (bn != BS_DONE) begin
                        next_step = bn;
                        next_tmr  = blank_len(ph, bn);
                    end else if (ph == PH_CLEAR) begin
                        lend = 1'b1;
                    end else if (ph == PH_EXPOSE) begin
                        next_st  = ST_PIX;
                        next_xe  = '0;
                        next_tmr = ld(C_XHALF);
                    end else begin
                        next_st   = ST_CAL;
                        next_step = cal_now ? 3'h0 : 3'h2;
                        next_tmr  = cal_now ? ld(C_CALDLY) : ld(C_CALOFF);
                    end
                end
            end
            ST_CAL: begin
                if (tmr == '0) begin
                    next_step = 3'(step + 3'h1);
                    next_tmr  = (step == 3'h0) ? ld(C_CAL) : ld(C_CALOFF);
                    if (step == 3'h0) begin
                        next_cal = 1'b0;
                    end
                    if (step == 3'h2) begin
                        next_st  = ST_PIX;
                        next_xe  = '0;
                        next_tmr = ld(C_XHALF);
                    end
                end
            end
            ST_PIX: begin
                if (tmr == '0) begin
                    if (pins.clk_x) begin
                        next_pins.clk_x = 1'b0;
                        next_tmr        = ld(C_XHALF);
                    end else if (xe == xtotal) begin
                        lend = 1'b1;
                    end else if (!(cap && readline(ph) && !fifo_ready)) begin
                        // a full buffer parks the clock low, the pixel output then holds
                        next_pins.clk_x = 1'b1;
                        next_tmr        = ld(C_XHALF);
                        push            = cap && readline(ph);
                        next_xe         = 12'(xe + 12'h001);
                    end
                end
            end
            ST_WAIT: begin
                next_exp = 32'(exp_cnt + 32'h1);
                if (exp_cnt == exposure_wait) begin
                    next_st    = ST_YSEL;
                    next_ph    = PH_SIGNAL;
                    next_step  = 3'h0;
                    next_tmr   = ld(C_YSYNC);
                    next_first = 1'b1;
                    next_row   = '0;
                    next_cal   = 1'b1;
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase

        if (lend) begin
            next_row   = 11'(row_cnt + 11'h001);
            next_first = 1'b0;
            next_st    = ST_YSEL;
            next_step  = 3'h0;
            next_tmr   = ld(C_YSYNC);
            if (11'(row_cnt + 11'h001) == rows) begin
                next_row   = '0;
                next_first = 1'b1;
                unique case (ph)
                    PH_EXPOSE: next_ph = PH_READ;
                    PH_CLEAR:  next_ph = PH_BLACK;
                    PH_BLACK: begin
                        next_ph  = PH_EXPWAIT;
                        next_st  = ST_WAIT;
                        next_exp = '0;
                    end
                    default: begin
                        next_st   = ST_IDLE;
                        next_done = 1'b1;
                    end
                endcase
            end
        end

        if (next_st != ST_PIX) begin
            next_pins.clk_x = 1'b0;
        end
        unique case (next_st)
            ST_LOAD: begin
                next_pins.addr = (next_step < 3'h3) ? win.start_row : win.start_col;
                next_pins.ld_y = next_step == 3'h1;
                next_pins.ld_x = next_step == 3'h4;
            end
            ST_YSEL: begin
                // first line of a pass loads the start row, later lines shift by one
                next_pins.sync_yrd  = next_first && next_step < 3'h2
                                      && (readline(next_ph) || next_ph == PH_EXPOSE);
                next_pins.sync_reset_line_pointer = next_first && next_step < 3'h2
                                      && next_ph inside {PH_EXPOSE, PH_CLEAR};
                next_pins.clk_yrd   = next_step == 3'h1
                                      && (readline(next_ph) || (next_first && next_ph == PH_EXPOSE));
                next_pins.clk_reset_line_pointer  = next_step == 3'h1
                                      && next_ph inside {PH_EXPOSE, PH_READ, PH_CLEAR};
                // the clear pass uses the reset pointer only; the select wraps the reset
                next_pins.pointer_select = next_ph == PH_CLEAR;
            end
            ST_BLANK: begin
                next_pins.blank          = 1'b1;
                next_pins.column_a       = next_step == BS_PRE;
                next_pins.samp_s         = next_step == BS_SIG;
                next_pins.samp_r         = next_step == BS_REF;
                next_pins.row_reset      = next_step == BS_RST;
                next_pins.pointer_select = next_ph == PH_CLEAR;
            end
            ST_CAL: begin
                next_pins.cal = next_step == 3'h1;
            end
            ST_PIX: begin
                next_pins.sync_x = next_xe == '0;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st         <= ST_IDLE;
            ph         <= PH_EXPOSE;
            step       <= 3'h0;
            tmr        <= 16'h0000;
            row_cnt    <= 11'h000;
            xe         <= 12'h000;
            exp_cnt    <= 32'h0;
            first      <= 1'b0;
            cal_pend   <= 1'b0;
            frame_done <= 1'b0;
            pins       <= '0;
            pix_s1     <= '0;
            pix_s2     <= '0;
        end else if (clk_en) begin
            st         <= next_st;
            ph         <= next_ph;
            step       <= next_step;
            tmr        <= next_tmr;
            row_cnt    <= next_row;
            xe         <= next_xe;
            exp_cnt    <= next_exp;
            first      <= next_first;
            cal_pend   <= next_cal;
            frame_done <= next_done;
            pins       <= next_pins;
            pix_s1     <= pix_pin;
            pix_s2     <= pix_s1;
        end
    end

    parsq_fifo #(
        .W (PIX_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (pix_s2),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !clk_en);

    logic act;
    assign act = pins.column_a || pins.samp_s || pins.samp_r || pins.row_reset;

    sequence ldy_13;
        pins.ld_y [*8] ##1 pins.ld_y [*5];
    endsequence

    sequence xlow_7;
        !pins.clk_x [*7];
    endsequence

    a_ldy_width: assert property ($rose(pins.ld_y) |-> ldy_13 ##1 !pins.ld_y)
        else $error("row start strobe width wrong");
    a_ldx_order: assert property ($rose(pins.ld_x) |->
        pins.addr == win.start_col && $past(pins.ld_y, 27) && !$past(pins.ld_y, 26))
        else $error("column load not after row load");
    a_expose_only: assert property ((st == ST_BLANK && ph == PH_EXPOSE) |->
        !pins.samp_s && !pins.samp_r && !pins.column_a)
        else $error("sampling during exposure run");
    a_pre_width: assert property ($rose(pins.column_a) |-> ##49 pins.column_a ##1 !pins.column_a)
        else $error("column amplifier pulse width wrong");
    a_blank_hold: assert property ($fell(pins.blank) |-> $past(act, 14) && !$past(act, 13))
        else $error("blanking hold after last activity wrong");
    a_cal_delay: assert property ($rose(pins.cal) |-> $past(pins.blank, 5) && !$past(pins.blank, 4))
        else $error("calibration not delayed after blanking");
    a_cal_width: assert property ($rose(pins.cal) |-> ##24 pins.cal ##1 !pins.cal)
        else $error("calibration width wrong");
    a_psel_reset: assert property (($rose(pins.row_reset) && ph == PH_CLEAR) |->
        pins.pointer_select && $past(pins.pointer_select, 13))
        else $error("pointer select setup missing");
    a_push_lat: assert property (push |-> readline(ph) && st == ST_PIX && xe >= 12'(PIX_LAT))
        else $error("pixel taken before latency");
    a_x_half: assert property ($rose(pins.clk_x) |-> pins.clk_x [*7] ##1 !pins.clk_x)
        else $error("pixel clock high phase wrong");
    a_x_after_cal: assert property ($fell(pins.cal) |-> xlow_7)
        else $error("shift too soon after calibration");
endmodule // parsq_ctrl

// ---- testbench/parsq_sensor_model.sv ----
`timescale 1ns/1ps
module parsq_sensor_model
    import parsq_pkg::*;
(
    input  wire parsq_pins_t        pins,
    output logic [PIX_W-1:0]        pix_pin
);
    logic [9:0] y_start;
    logic [9:0] rd_ptr;
    logic       calibrated;
    logic       x_synced;
    int         x_rises;

    initial begin
        y_start = '0;
        rd_ptr = '0;
        calibrated = 1'b0;
        x_synced = 1'b0;
        x_rises = 0;
    end

    always @(negedge pins.ld_y) begin
        y_start = pins.addr;
        calibrated = 1'b0;
    end

    always @(posedge pins.clk_yrd) begin
        rd_ptr = pins.sync_yrd ? y_start : rd_ptr + 10'h1;
    end

    always @(posedge pins.cal) calibrated = 1'b1;

    // blanking wipes the column shift register, so a fresh sync is needed
    always @(posedge pins.blank) begin
        x_synced = 1'b0;
        x_rises = 0;
    end

    always @(posedge pins.sync_x) x_synced = 1'b1;

    always @(posedge pins.clk_x) x_rises++;

    // inverted row until the output pipe has filled, so early capture shows
    assign pix_pin = (calibrated && x_synced && x_rises >= PIX_LAT) ? {2'h0, rd_ptr} : ~{2'h0, rd_ptr};
endmodule // parsq_sensor_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import parsq_pkg::*;
    logic             clk;
    logic             sys_rst;
    logic             clk_en;
    logic             start;
    logic             destructive_mode;
    logic             cal_each_line;
    logic             out_ready;
    parsq_win_t       win;
    logic [9:0]       exposure_lines;
    logic [31:0]      exposure_wait;
    logic [PIX_W-1:0] pix_pin;
    logic [PIX_W-1:0] out_data;
    logic             out_valid;
    logic             busy;
    logic             frame_done;
    parsq_pins_t      pins;
    int               error_cnt;
    int               n_checks;
    int               cyc;
    int               seed;
    logic [PIX_W-1:0] exp_q[$];

    parsq_ctrl dut (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .start(start),
        .destructive_mode(destructive_mode), .win(win), .exposure_lines(exposure_lines),
        .exposure_wait(exposure_wait), .cal_each_line(cal_each_line), .pix_pin(pix_pin),
        .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data), .busy(busy),
        .frame_done(frame_done), .pins(pins)
    );

    parsq_sensor_model model (
        .pins(pins),
        .pix_pin(pix_pin)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic run_frame(input logic dm, input logic [9:0] r0, input logic [9:0] r1,
                             input logic [9:0] c0, input logic [9:0] c1, input logic [9:0] el,
                             input logic cel);
        int passes;
        passes = dm ? 1 : 2;
        destructive_mode = dm;
        win = '{r0, c0, r1, c1};
        exposure_lines = el;
        cal_each_line = cel;
        exposure_wait = $random(seed) & 32'hff;
        for (int p = 0; p < passes; p++) begin
            for (int r = r0; r <= r1; r++) begin
                for (int c = c0; c <= c1; c++) begin
                    exp_q.push_back({2'h0, r[9:0]});
                end
            end
        end
        start = 1'b1;
        @(posedge clk) #1 start = 1'b0;
        @(posedge clk) #1;
        check("busy", busy, 32'h1);
        // a second start while busy must be ignored
        start = 1'b1;
        @(posedge clk) #1 start = 1'b0;
        @(posedge clk iff frame_done);
        #1 check("busy_end", busy, 32'h0);
        // outlast a whole stall window so the last buffered words can drain
        repeat (700) @(posedge clk);
        #1 check("words_left", exp_q.size(), 32'h0);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // a stall window each 600 cycles fills the fifo and parks the pixel clock
    initial forever begin
        @(posedge clk);
        #1 out_ready = (cyc % 600 > 200) && ($random(seed) % 2 != 0);
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc > 160000) begin
            error_cnt++;
            summarize();
        end else if (out_valid && out_ready) begin
            if (exp_q.size() == 0) check("extra_word", 32'h1, 32'h0);
            else check("pixel", out_data, exp_q.pop_front());
        end
    end

    initial begin
        seed = 63816;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        start = 1'b0;
        out_ready = 1'b0;
        destructive_mode = 1'b1;
        win = '0;
        exposure_lines = 10'h1;
        exposure_wait = 32'h0;
        cal_each_line = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        cyc = 0;
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        check("idle_busy", busy, 32'h0);
        run_frame(1'b1, 10'h2, 10'h4, 10'h4, 10'h8, 10'h1, 1'b0);
        run_frame(1'b1, 10'h3fe, 10'h3ff, 10'h0, 10'h4, 10'h2, 1'b1);
        run_frame(1'b0, 10'h5, 10'h6, 10'h3fb, 10'h3ff, 10'h0, 1'b0);
        summarize();
    end
endmodule // testbench
